/* File: irq_bank_pkg.sv */
// constants for the peripheral interrupt flag and enable bank
//
// Notes on behaviour
// - enable bits 6,1,0 writable, reset zero
// - unimplemented bits read zero, ignore writes
// - timer zero overflow sets sticky bit 5
// - pin-change bit 4 is OR of ports
// - external pin event sets sticky bit 0
// - flags set regardless of any enable
// - timer one gate close sets bit 7
// - conversion done sets bit 6
// - receive bit 5 mirrors buffer not empty
// - transmit bit 4 mirrors buffer empty
// - sync port completion sets sticky bit 3
// - bus collision sets sticky bit 2
// - timer two period match sets bit 1
// - timer one overflow sets bit 0
// - comparator flags bits 6 and 5
// - nonvolatile task done sets bit 4
// - oscillator rollover sets bit 0
// - peripheral gate enable must allow requests
// - global enable passes or blocks all
package irq_bank_pkg;

   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 8;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_ENABLE_4 = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_FLAGS_0  = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_FLAGS_1  = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_FLAGS_2  = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_CONTROL  = 5'h10;

   // ==========================================================
   // implemented-bit masks
   localparam logic [REG_W-1:0] MASK_ENABLE_4 = 8'h43;
   localparam logic [REG_W-1:0] MASK_FLAGS_0  = 8'h31;
   localparam logic [REG_W-1:0] MASK_FLAGS_1  = 8'hFF;
   localparam logic [REG_W-1:0] MASK_FLAGS_2  = 8'h71;
   localparam logic [REG_W-1:0] MASK_CONTROL  = 8'hC0;
   // software-writable flag bits (read-only mirrors excluded)
   localparam logic [REG_W-1:0] WR_FLAGS_0    = 8'h21;
   localparam logic [REG_W-1:0] WR_FLAGS_1    = 8'hCF;
   localparam logic [REG_W-1:0] RESET_VALUE   = 8'h00;

   // ==========================================================
   // bit positions
   localparam int unsigned BIT_WAVEFORM_GEN_EN = 6;
   localparam int unsigned BIT_CAPCOMP_B_EN    = 1;
   localparam int unsigned BIT_CAPCOMP_A_EN    = 0;
   localparam int unsigned BIT_TIMER_ZERO_OVF  = 5;
   localparam int unsigned BIT_PIN_CHANGE      = 4;
   localparam int unsigned BIT_EXT_PIN         = 0;
   localparam int unsigned BIT_TIMER_ONE_GATE  = 7;
   localparam int unsigned BIT_CONVERTER_DONE  = 6;
   localparam int unsigned BIT_SERIAL_RX       = 5;
   localparam int unsigned BIT_SERIAL_TX       = 4;
   localparam int unsigned BIT_SYNC_PORT       = 3;
   localparam int unsigned BIT_BUS_COLLISION   = 2;
   localparam int unsigned BIT_TIMER_TWO_MATCH = 1;
   localparam int unsigned BIT_TIMER_ONE_OVF   = 0;
   localparam int unsigned BIT_COMPARATOR_B    = 6;
   localparam int unsigned BIT_COMPARATOR_A    = 5;
   localparam int unsigned BIT_NONVOLATILE     = 4;
   localparam int unsigned BIT_OSC_ROLLOVER    = 0;
   localparam int unsigned BIT_GLOBAL_EN       = 7;
   localparam int unsigned BIT_PERIPH_GATE_EN  = 6;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_ENABLE_4,
      SEL_FLAGS_0,
      SEL_FLAGS_1,
      SEL_FLAGS_2,
      SEL_CONTROL
   } reg_sel_e;

   typedef enum {
      BUS_IDLE,
      BUS_ANSWER
   } bus_state_e;

endpackage

/* File: irq_flag_bank.sv */
// peripheral interrupt flag and enable bank with an Avalon-MM slave
module irq_flag_bank
   import irq_bank_pkg::*;
#(
   parameter int unsigned PORT_COUNT     = 3,
   parameter bit          HAS_COMPARATOR_B = 1'b1
)
(
   input  wire logic                             ref_clk_i,
   input  wire logic                             rst_b_i,
   input  wire logic [irq_bank_pkg::ADDR_W-1:0]  avs_address_i,
   input  wire logic                             avs_read_i,
   input  wire logic                             avs_write_i,
   input  wire logic [irq_bank_pkg::DATA_W-1:0]  avs_writedata_i,
   output logic      [irq_bank_pkg::DATA_W-1:0]  avs_readdata_o,
   output logic                                  avs_waitrequest_o,
   input  wire logic                             timer_zero_ovf_i,
   input  wire logic [PORT_COUNT-1:0]            port_change_flags_i,
   input  wire logic                             ext_pin_irq_i,
   input  wire logic                             timer_one_gate_close_i,
   input  wire logic                             converter_done_i,
   input  wire logic                             rx_buf_not_empty_i,
   input  wire logic                             tx_buf_empty_i,
   input  wire logic                             sync_port_done_i,
   input  wire logic                             bus_collision_i,
   input  wire logic                             timer_two_match_i,
   input  wire logic                             timer_one_ovf_i,
   input  wire logic                             comparator_a_i,
   input  wire logic                             comparator_b_i,
   input  wire logic                             nonvolatile_done_i,
   input  wire logic                             oscillator_rollover_i,
   input  wire logic [irq_bank_pkg::REG_W-1:0]   flags_0_en_i,
   input  wire logic [irq_bank_pkg::REG_W-1:0]   flags_1_en_i,
   input  wire logic [irq_bank_pkg::REG_W-1:0]   flags_2_en_i,
   input  wire logic [irq_bank_pkg::REG_W-1:0]   flags_4_i,
   output logic      [irq_bank_pkg::REG_W-1:0]   enable_4_o,
   output logic                                  irq_req_o
);
   import irq_bank_pkg::*;

   // ==========================================================
   // address decode
   function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
      reg_sel_e sel;
      sel = SEL_NONE;
      case (addr)
         OFF_ENABLE_4: sel = SEL_ENABLE_4;
         OFF_FLAGS_0:  sel = SEL_FLAGS_0;
         OFF_FLAGS_1:  sel = SEL_FLAGS_1;
         OFF_FLAGS_2:  sel = SEL_FLAGS_2;
         OFF_CONTROL:  sel = SEL_CONTROL;
         default:      sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   // ==========================================================
   // bus handshake: one wait cycle, then the answer cycle
   bus_state_e            bus_q;
   bus_state_e            bus_d;
   logic [DATA_W-1:0]     rdata_q;
   logic [DATA_W-1:0]     rdata_d;
   reg_sel_e              sel;
   logic                  wr_take;
   logic [REG_W-1:0]      wbyte;

   logic [REG_W-1:0]      enable_4_q;
   logic [REG_W-1:0]      enable_4_d;
   logic [REG_W-1:0]      flags_0_q;
   logic [REG_W-1:0]      flags_0_d;
   logic [REG_W-1:0]      flags_1_q;
   logic [REG_W-1:0]      flags_1_d;
   logic [REG_W-1:0]      flags_2_q;
   logic [REG_W-1:0]      flags_2_d;
   logic [REG_W-1:0]      control_q;
   logic [REG_W-1:0]      control_d;
   logic [REG_W-1:0]      set_0;
   logic [REG_W-1:0]      set_1;
   logic [REG_W-1:0]      set_2;
   logic [REG_W-1:0]      mask_2;
   logic [REG_W-1:0]      view_0;
   logic [REG_W-1:0]      view_1;
   logic                  pending;
   logic                  irq_req_q;
   logic                  irq_req_d;

   assign sel               = decode(avs_address_i);
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (bus_q != BUS_ANSWER);
   assign wr_take           = avs_write_i & (bus_q == BUS_ANSWER);
   assign wbyte             = avs_writedata_i[REG_W-1:0];

   // ==========================================================
   // live views of flag registers
   always_comb
   begin
      view_0 = flags_0_q;
      view_0[BIT_PIN_CHANGE] = |port_change_flags_i;
      view_0 = view_0 & MASK_FLAGS_0;
      view_1 = flags_1_q;
      view_1[BIT_SERIAL_RX] = rx_buf_not_empty_i;
      view_1[BIT_SERIAL_TX] = tx_buf_empty_i;
      mask_2 = MASK_FLAGS_2;
      if (!HAS_COMPARATOR_B)
      begin
         mask_2[BIT_COMPARATOR_B] = 1'b0;
      end
   end

   // ==========================================================
   // event set vectors, taken whatever the enables hold
   always_comb
   begin
      set_0 = RESET_VALUE;
      set_1 = RESET_VALUE;
      set_2 = RESET_VALUE;
      set_0[BIT_TIMER_ZERO_OVF]  = timer_zero_ovf_i;
      set_0[BIT_EXT_PIN]         = ext_pin_irq_i;
      set_1[BIT_TIMER_ONE_GATE]  = timer_one_gate_close_i;
      set_1[BIT_CONVERTER_DONE]  = converter_done_i;
      set_1[BIT_SYNC_PORT]       = sync_port_done_i;
      set_1[BIT_BUS_COLLISION]   = bus_collision_i;
      set_1[BIT_TIMER_TWO_MATCH] = timer_two_match_i;
      set_1[BIT_TIMER_ONE_OVF]   = timer_one_ovf_i;
      set_2[BIT_COMPARATOR_B]    = comparator_b_i;
      set_2[BIT_COMPARATOR_A]    = comparator_a_i;
      set_2[BIT_NONVOLATILE]     = nonvolatile_done_i;
      set_2[BIT_OSC_ROLLOVER]    = oscillator_rollover_i;
   end

   // ==========================================================
   // next register values; a hardware set beats a software clear
   always_comb
   begin
      enable_4_d = enable_4_q;
      control_d  = control_q;
      flags_0_d  = flags_0_q;
      flags_1_d  = flags_1_q;
      flags_2_d  = flags_2_q;
      if (wr_take)
      begin
         case (sel)
            SEL_ENABLE_4: enable_4_d = wbyte & MASK_ENABLE_4;
            SEL_FLAGS_0:  flags_0_d  = wbyte & WR_FLAGS_0;
            SEL_FLAGS_1:  flags_1_d  = wbyte & WR_FLAGS_1;
            SEL_FLAGS_2:  flags_2_d  = wbyte & mask_2;
            SEL_CONTROL:  control_d  = wbyte & MASK_CONTROL;
            default:      control_d  = control_q;
         endcase
      end
      flags_0_d = (flags_0_d | set_0) & WR_FLAGS_0;
      flags_1_d = (flags_1_d | set_1) & WR_FLAGS_1;
      flags_2_d = (flags_2_d | set_2) & mask_2;
   end

   // ==========================================================
   // request gating
   always_comb
   begin
      pending   = |(view_0 & flags_0_en_i) | |(view_1 & flags_1_en_i)
                | |(flags_2_q & flags_2_en_i) | |(flags_4_i & enable_4_q);
      irq_req_d = pending & control_q[BIT_PERIPH_GATE_EN]
                & control_q[BIT_GLOBAL_EN];
   end

   // ==========================================================
   // bus next state and read data
   always_comb
   begin
      bus_d   = BUS_IDLE;
      rdata_d = rdata_q;
      case (bus_q)
         BUS_IDLE:
         begin
            if (avs_read_i | avs_write_i)
            begin
               bus_d   = BUS_ANSWER;
               rdata_d = '0;
               case (sel)
                  SEL_ENABLE_4: rdata_d[REG_W-1:0] = enable_4_q;
                  SEL_FLAGS_0:  rdata_d[REG_W-1:0] = view_0;
                  SEL_FLAGS_1:  rdata_d[REG_W-1:0] = view_1;
                  SEL_FLAGS_2:  rdata_d[REG_W-1:0] = flags_2_q;
                  SEL_CONTROL:  rdata_d[REG_W-1:0] = control_q;
                  default:      rdata_d = '0;
               endcase
            end
         end
         BUS_ANSWER: bus_d = BUS_IDLE;
         default:    bus_d = BUS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         bus_q      <= BUS_IDLE;
         rdata_q    <= '0;
         enable_4_q <= RESET_VALUE;
         flags_0_q  <= RESET_VALUE;
         flags_1_q  <= RESET_VALUE;
         flags_2_q  <= RESET_VALUE;
         control_q  <= RESET_VALUE;
         irq_req_q  <= 1'b0;
      end
      else
      begin
         bus_q      <= bus_d;
         rdata_q    <= rdata_d;
         enable_4_q <= enable_4_d;
         flags_0_q  <= flags_0_d;
         flags_1_q  <= flags_1_d;
         flags_2_q  <= flags_2_d;
         control_q  <= control_d;
         irq_req_q  <= irq_req_d;
      end
   end

   assign avs_readdata_o = rdata_q;
   assign enable_4_o     = enable_4_q;
   assign irq_req_o      = irq_req_q;

   // ==========================================================
   // checks
   property p_enable_unimpl;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (enable_4_q & ~MASK_ENABLE_4) == 8'h00;
   endproperty
   a_enable_unimpl: assert property (p_enable_unimpl)
      else $error("unimplemented enable bit set");

   property p_enable_write;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_take && sel == SEL_ENABLE_4 |=> enable_4_q == ($past(wbyte) & MASK_ENABLE_4);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable write not stored");

   property p_timer_zero_sticky;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      timer_zero_ovf_i |=> flags_0_q[BIT_TIMER_ZERO_OVF];
   endproperty
   a_timer_zero_sticky: assert property (p_timer_zero_sticky)
      else $error("timer zero overflow flag not set");

   property p_ext_pin_hold;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      flags_0_q[BIT_EXT_PIN] && !(wr_take && sel == SEL_FLAGS_0)
      |=> flags_0_q[BIT_EXT_PIN];
   endproperty
   a_ext_pin_hold: assert property (p_ext_pin_hold)
      else $error("external pin flag dropped without a write");

   property p_pin_change_or;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      bus_q == BUS_IDLE && avs_read_i && sel == SEL_FLAGS_0
      |=> avs_readdata_o[BIT_PIN_CHANGE] == $past(|port_change_flags_i);
   endproperty
   a_pin_change_or: assert property (p_pin_change_or)
      else $error("pin change flag differs from port flags");

   property p_rx_read;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      bus_q == BUS_IDLE && avs_read_i && sel == SEL_FLAGS_1
      |=> avs_readdata_o[BIT_SERIAL_RX] == $past(rx_buf_not_empty_i)
          && avs_readdata_o[BIT_SERIAL_TX] == $past(tx_buf_empty_i);
   endproperty
   a_rx_read: assert property (p_rx_read)
      else $error("serial mirror bits read wrong");

   property p_set_wins;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_take && sel == SEL_FLAGS_1 && sync_port_done_i |=> flags_1_q[BIT_SYNC_PORT];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("sync port event lost against a clear");

   property p_gate_blocks;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !control_q[BIT_GLOBAL_EN] || !control_q[BIT_PERIPH_GATE_EN] |=> !irq_req_o;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks)
      else $error("request passed a closed gate");

   property p_request;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      control_q[BIT_GLOBAL_EN] && control_q[BIT_PERIPH_GATE_EN]
      && (flags_1_q[BIT_TIMER_ONE_OVF] && flags_1_en_i[BIT_TIMER_ONE_OVF]) |=> irq_req_o;
   endproperty
   a_request: assert property (p_request)
      else $error("enabled flag raised no request");

   property p_answer_time;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(avs_read_i) && bus_q == BUS_IDLE |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty
   a_answer_time: assert property (p_answer_time)
      else $error("answer not on second cycle");

   // read-only mirrors and unused bits must never be stored in the flag registers
   property p_flags_unimpl;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (flags_0_q & ~WR_FLAGS_0) == 8'h00 && (flags_1_q & ~WR_FLAGS_1) == 8'h00
      && (flags_2_q & ~MASK_FLAGS_2) == 8'h00;
   endproperty
   a_flags_unimpl: assert property (p_flags_unimpl)
      else $error("unimplemented flag bit set");

   property p_gate_close_sets;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      timer_one_gate_close_i |=> flags_1_q[BIT_TIMER_ONE_GATE];
   endproperty
   a_gate_close_sets: assert property (p_gate_close_sets)
      else $error("timer one gate flag not set");

   property p_converter_sets;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      converter_done_i |=> flags_1_q[BIT_CONVERTER_DONE];
   endproperty
   a_converter_sets: assert property (p_converter_sets)
      else $error("converter flag not set");

   property p_timer_two_sets;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      timer_two_match_i |=> flags_1_q[BIT_TIMER_TWO_MATCH];
   endproperty
   a_timer_two_sets: assert property (p_timer_two_sets)
      else $error("timer two match flag not set");

   property p_timer_one_sets;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      timer_one_ovf_i |=> flags_1_q[BIT_TIMER_ONE_OVF];
   endproperty
   a_timer_one_sets: assert property (p_timer_one_sets)
      else $error("timer one overflow flag not set");

   property p_nonvolatile_sets;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      nonvolatile_done_i |=> flags_2_q[BIT_NONVOLATILE];
   endproperty
   a_nonvolatile_sets: assert property (p_nonvolatile_sets)
      else $error("nonvolatile flag not set");

   property p_rollover_sets;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      oscillator_rollover_i |=> flags_2_q[BIT_OSC_ROLLOVER];
   endproperty
   a_rollover_sets: assert property (p_rollover_sets)
      else $error("oscillator rollover flag not set");

endmodule

/* File: event_src_model.sv */
// peripheral event source model: one-cycle event pulses on command
module event_src_model
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        fire_i,
   input  wire logic [3:0]  fire_sel_i,
   output logic      [11:0] pulse_o
);
   logic [11:0] pulse_d;
   logic [11:0] pulse_q;

   // ==========================================
   // event pulses
   // a source reports each finished condition as one pulse, never a level
   always_comb
   begin
      pulse_d = 12'h000;
      if (fire_i)
      begin
         pulse_d[fire_sel_i] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pulse_q <= 12'h000;
      end
      else
      begin
         pulse_q <= pulse_d;
      end
   end

   assign pulse_o = pulse_q;
endmodule

/* File: tb.sv */
// self-checking testbench for the peripheral interrupt flag and enable bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_bank_pkg::*;

   logic               ref_clk_i;
   logic               rst_b_i;
   logic [ADDR_W-1:0]  avs_address_i;
   logic               avs_read_i;
   logic               avs_write_i;
   logic [DATA_W-1:0]  avs_writedata_i;
   logic [DATA_W-1:0]  avs_readdata_o;
   logic               avs_waitrequest_o;
   logic [2:0]         port_chg;
   logic               rx_full;
   logic               tx_empty;
   logic [REG_W-1:0]   en0;
   logic [REG_W-1:0]   en1;
   logic [REG_W-1:0]   en2;
   logic [REG_W-1:0]   flags4;
   logic [REG_W-1:0]   enable_4_o;
   logic               irq_req_o;
   logic               fire;
   logic [3:0]         fire_sel;
   logic [11:0]        pulse;
   logic [31:0]        exp_q[$];
   int                 num_errors = 0;
   int                 checks_done = 0;
   int                 i;
   logic [4:0]         ev_off[12] = '{5'h04, 5'h04, 5'h08, 5'h08, 5'h08, 5'h08,
                                      5'h08, 5'h08, 5'h0C, 5'h0C, 5'h0C, 5'h0C};
   int                 ev_bit[12] = '{5, 0, 7, 6, 3, 2, 1, 0, 6, 5, 4, 0};
   logic [7:0]         ff_exp[6]  = '{8'h43, 8'h21, 8'hCF, 8'h71, 8'hC0, 8'h00};

   always #10 ref_clk_i = ~ref_clk_i;

   event_src_model src (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .fire_i(fire),
                        .fire_sel_i(fire_sel), .pulse_o(pulse));

   irq_flag_bank uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .timer_zero_ovf_i(pulse[0]),
      .port_change_flags_i(port_chg), .ext_pin_irq_i(pulse[1]),
      .timer_one_gate_close_i(pulse[2]), .converter_done_i(pulse[3]),
      .rx_buf_not_empty_i(rx_full), .tx_buf_empty_i(tx_empty),
      .sync_port_done_i(pulse[4]), .bus_collision_i(pulse[5]),
      .timer_two_match_i(pulse[6]), .timer_one_ovf_i(pulse[7]),
      .comparator_b_i(pulse[8]), .comparator_a_i(pulse[9]),
      .nonvolatile_done_i(pulse[10]), .oscillator_rollover_i(pulse[11]),
      .flags_0_en_i(en0), .flags_1_en_i(en1), .flags_2_en_i(en2), .flags_4_i(flags4),
      .enable_4_o(enable_4_o), .irq_req_o(irq_req_o));

   // ==========================================
   // helpers
   task check_value(input string name, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, e, s);
      end
   endtask

   // holds the request until waitrequest is seen low at a rising edge
   task bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [7:0] e);
      int   n;
      logic rdy;
      n = 0;
      rdy = 1'b0;
      if (!wr)
         exp_q.push_back({24'h000000, e});
      avs_address_i   <= a;
      avs_read_i      <= !wr;
      avs_write_i     <= wr;
      avs_writedata_i <= {24'hFFFFFF, d};
      while (!rdy && n < 50)
      begin
         @(posedge ref_clk_i);
         rdy = (avs_waitrequest_o === 1'b0);
         n++;
      end
      if (!rdy)
      begin
         num_errors++;
         $display("unexpected avs_waitrequest_o expected 0 seen 1");
      end
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task pulse_event(input int k);
      fire     <= 1'b1;
      fire_sel <= 4'(k);
      @(posedge ref_clk_i);
      fire <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask

   task irq_is(input logic e);
      repeat (3) @(posedge ref_clk_i);
      check_value("irq_req_o", {31'h0, e}, {31'h0, irq_req_o});
   endtask

   task finish_test;
      $display("checks_done %0d num_errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================
   // read monitor: read data taken at the very edge that accepts the read
   always @(posedge ref_clk_i)
   begin
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
      begin
         if (exp_q.size() > 0)
            check_value("avs_readdata_o", exp_q.pop_front(), avs_readdata_o);
         else
            check_value("read count", 32'h0, 32'h1);
      end
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      finish_test();
   end

   // ==========================================
   // main sequence
   initial
   begin
      {ref_clk_i, rst_b_i, avs_read_i, avs_write_i, fire, rx_full, tx_empty} = 7'h00;
      {avs_address_i, avs_writedata_i, fire_sel, port_chg} = '0;
      {en0, en1, en2, flags4} = 32'h0;
      void'($urandom(32'h218ECF4B));
      repeat (20) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      for (i = 0; i < 6; i++)
         bus(1'b0, 5'(i * 4), 8'h00, 8'h00);
      check_value("enable_4_o", 32'h0, {24'h0, enable_4_o});
      for (i = 0; i < 6; i++)
      begin
         bus(1'b1, 5'(i * 4), 8'hFF, 8'h00);
         bus(1'b0, 5'(i * 4), 8'h00, ff_exp[i]);
         bus(1'b1, 5'(i * 4), 8'h00, 8'h00);
         bus(1'b0, 5'(i * 4), 8'h00, 8'h00);
      end
      // enables held off: flags must still set and stay set
      for (i = 0; i < 12; i++)
      begin
         pulse_event(i);
         bus(1'b0, ev_off[i], 8'h00, 8'(1 << ev_bit[i]));
         bus(1'b1, ev_off[i], 8'h00, 8'h00);
         bus(1'b0, ev_off[i], 8'h00, 8'h00);
      end
      for (i = 0; i < 8; i++)
      begin
         port_chg <= 3'($urandom);
         rx_full  <= 1'($urandom);
         tx_empty <= 1'($urandom);
         @(posedge ref_clk_i);
         bus(1'b1, OFF_FLAGS_0, 8'h00, 8'h00);
         bus(1'b0, OFF_FLAGS_0, 8'h00, {3'h0, |port_chg, 4'h0});
         bus(1'b0, OFF_FLAGS_1, 8'h00, {2'h0, rx_full, tx_empty, 4'h0});
      end
      {port_chg, rx_full, tx_empty} <= 5'h00;
      // flag is already clear before its enable goes up
      en1 <= 8'h01;
      pulse_event(7);
      irq_is(1'b0);
      bus(1'b1, OFF_CONTROL, 8'h80, 8'h00);
      irq_is(1'b0);
      bus(1'b1, OFF_CONTROL, 8'h40, 8'h00);
      irq_is(1'b0);
      bus(1'b1, OFF_CONTROL, 8'hC0, 8'h00);
      irq_is(1'b1);
      bus(1'b1, OFF_FLAGS_1, 8'h00, 8'h00);
      irq_is(1'b0);
      en0      <= 8'h10;
      port_chg <= 3'h4;
      irq_is(1'b1);
      {en0, port_chg, flags4} <= {8'h00, 3'h0, 8'h40};
      irq_is(1'b0);
      bus(1'b1, OFF_ENABLE_4, 8'h40, 8'h00);
      check_value("enable_4_o", 32'h40, {24'h0, enable_4_o});
      irq_is(1'b1);
      en2 <= 8'h01;
      bus(1'b1, OFF_ENABLE_4, 8'h00, 8'h00);
      pulse_event(11);
      irq_is(1'b1);
      bus(1'b1, OFF_CONTROL, 8'h00, 8'h00);
      irq_is(1'b0);
      repeat (4) @(posedge ref_clk_i);
      finish_test();
   end
endmodule
